// [hdl/flag_condition_evaluator.sv]
// flag condition evaluator top: registered result and register port
// Function
// - decide only from the five status flags
// - four-bit subcode selects one of sixteen tests
// - one evaluator serves all four instruction groups
// - single-flag tests: overflow, zero, sign, parity
// - 0010 carry set, 0011 carry clear
// - 0110 carry or zero, 0111 its negation
// - 1100 sign xor overflow, 1101 negated
// - 1110 signed less or equal
// - 1111 signed strictly greater
// - unsigned relations use carry and zero
// - signed relations use sign, overflow, zero
// - alias names share one subcode and result
`timescale 1ns/1ps
module flag_condition_evaluator (
    input  wire logic                              i_clk_sys,
    input  wire logic                              i_rst,
    input  wire logic                              i_ce,
    // evaluation request from the decoder
    input  wire logic                              i_eval_valid,
    input  wire logic [cond_eval_pkg::SUB_W-1:0]   i_subcode,
    input  wire cond_eval_pkg::insn_group_t        i_group,
    // flags from the processor_status_word
    input  wire logic                              i_carry_flag,
    input  wire logic                              i_overflow_flag,
    input  wire logic                              i_sign_flag,
    input  wire logic                              i_zero_flag,
    input  wire logic                              i_parity_flag,
    // registered answer
    output logic                                   o_result_valid,
    output logic                                   o_cond_true,
    output cond_eval_pkg::insn_group_t             o_group,
    // register port
    input  wire logic [cond_eval_pkg::REG_AW-1:0]  i_reg_addr,
    input  wire logic [cond_eval_pkg::REG_DW-1:0]  i_reg_wdata,
    input  wire logic                              i_reg_wr,
    input  wire logic                              i_reg_rd,
    output logic [cond_eval_pkg::REG_DW-1:0]       o_reg_rdata
);
    import cond_eval_pkg::*;

    cond_eval_if   core_bus ();                      // link to the test core
    status_flags_t flags_now;                        // flags packed for the core

    logic          enable_r;                         // evaluator enable
    logic          take_eval;                        // request accepted this cycle
    logic          clr_cnt;                          // counter clear strobe

    logic [SUB_W-1:0]  last_sub_r;                   // snapshot of last subcode
    status_flags_t     last_flags_r;                 // snapshot of last flags
    logic              last_result_r;                // snapshot of last result
    insn_group_t       last_group_r;                 // snapshot of last group
    logic [REG_DW-1:0] eval_cnt_r;                   // evaluations taken
    logic [REG_DW-1:0] true_cnt_r;                   // true outcomes
    logic [REG_DW-1:0] rdata_nxt;                    // read mux

    // flags come from same-clock logic, so no synchroniser is needed
    always_comb begin
        flags_now.carry_flag    = i_carry_flag;
        flags_now.overflow_flag = i_overflow_flag;
        flags_now.sign_flag     = i_sign_flag;
        flags_now.zero_flag     = i_zero_flag;
        flags_now.parity_flag   = i_parity_flag;
    end

    // group is not fed to the core: every group sees the same test
    assign core_bus.subcode = i_subcode;
    assign core_bus.flags   = flags_now;

    // shared combinational test; aliases reach it only as the same subcode
    condition_test_core u_core (
        .bus (core_bus.evaluator)
    );

    assign take_eval = i_eval_valid & enable_r;
    assign clr_cnt   = i_reg_wr & (i_reg_addr == OFF_CTRL) & i_reg_wdata[CTRL_CLR_BIT];

    // control register; clear bit is a strobe and is not stored
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            enable_r <= CTRL_RST[CTRL_EN_BIT];
        end else if (i_ce) begin
            if (i_reg_wr && i_reg_addr == OFF_CTRL) begin
                enable_r <= i_reg_wdata[CTRL_EN_BIT];
            end
        end
    end

    // answer one cycle after the request; disabled requests give no pulse
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_result_valid <= 1'b0;
            o_cond_true    <= 1'b0;
            o_group        <= GRP_COND_JUMP;
        end else if (i_ce) begin
            o_result_valid <= take_eval;
            if (take_eval) begin
                o_cond_true <= core_bus.cond_true;
                o_group     <= i_group;
            end
        end
    end

    // snapshot of the latest accepted evaluation for software
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            last_sub_r    <= '0;
            last_flags_r  <= '0;
            last_result_r <= 1'b0;
            last_group_r  <= GRP_COND_JUMP;
        end else if (i_ce && take_eval) begin
            last_sub_r    <= i_subcode;
            last_flags_r  <= flags_now;
            last_result_r <= core_bus.cond_true;
            last_group_r  <= i_group;
        end
    end

    // counters wrap; an evaluation in the clear cycle is still counted
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            eval_cnt_r <= CNT_RST;
            true_cnt_r <= CNT_RST;
        end else if (i_ce) begin
            if (clr_cnt) begin
                eval_cnt_r <= take_eval ? 32'h0000_0001 : CNT_RST;
                true_cnt_r <= (take_eval && core_bus.cond_true) ? 32'h0000_0001 : CNT_RST;
            end else if (take_eval) begin
                eval_cnt_r <= eval_cnt_r + 32'h0000_0001;
                if (core_bus.cond_true) begin
                    true_cnt_r <= true_cnt_r + 32'h0000_0001;
                end
            end
        end
    end

    // read decode; unmapped offsets and idle cycles read as zero
    always_comb begin
        rdata_nxt = '0;
        if (!i_reg_rd) begin
            rdata_nxt = '0;
        end else if (i_reg_addr == OFF_CTRL) begin
            rdata_nxt[CTRL_EN_BIT] = enable_r;
        end else if (i_reg_addr == OFF_STATUS) begin
            rdata_nxt[STAT_RESULT_BIT]                  = last_result_r;
            rdata_nxt[STAT_SUB_LSB +: SUB_W]            = last_sub_r;
            rdata_nxt[STAT_FLAGS_LSB +: 5]              = last_flags_r;
            rdata_nxt[STAT_GROUP_LSB +: 2]              = last_group_r;
        end else if (i_reg_addr == OFF_EVAL_CNT) begin
            rdata_nxt = eval_cnt_r;
        end else if (i_reg_addr == OFF_TRUE_CNT) begin
            rdata_nxt = true_cnt_r;
        end else begin
            rdata_nxt = '0;
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_reg_rdata <= '0;
        end else if (i_ce) begin
            o_reg_rdata <= rdata_nxt;
        end
    end
endmodule : flag_condition_evaluator

// [hdl/cond_eval_pkg.sv]
// shared constants and types for the flag condition evaluator
package cond_eval_pkg;

    // register port geometry
    localparam int REG_AW = 8;                       // register address width
    localparam int REG_DW = 32;                      // register data width

    // register byte offsets
    localparam logic [REG_AW-1:0] OFF_CTRL     = 8'h00; // control
    localparam logic [REG_AW-1:0] OFF_STATUS   = 8'h04; // last evaluation snapshot
    localparam logic [REG_AW-1:0] OFF_EVAL_CNT = 8'h08; // evaluations taken
    localparam logic [REG_AW-1:0] OFF_TRUE_CNT = 8'h0c; // evaluations that came out true

    // control field positions and reset value
    localparam int CTRL_EN_BIT  = 0;                 // evaluator enable
    localparam int CTRL_CLR_BIT = 1;                 // write one to zero both counters
    localparam logic [REG_DW-1:0] CTRL_RST = 32'h0000_0001;

    // status field positions
    localparam int STAT_RESULT_BIT = 0;              // last result
    localparam int STAT_SUB_LSB    = 4;              // last subcode, 4 bits
    localparam int STAT_FLAGS_LSB  = 8;              // last flags, 5 bits
    localparam int STAT_GROUP_LSB  = 16;             // last instruction group, 2 bits

    // counter reset value
    localparam logic [REG_DW-1:0] CNT_RST = 32'h0000_0000;

    // subcode width: sixteen codes 0000 to 1111
    localparam int SUB_W = 4;

    // base test selected by the upper three subcode bits
    typedef enum logic [2:0] {
        BT_OVERFLOW      = 3'b000,                   // overflow set
        BT_CARRY         = 3'b001,                   // unsigned below
        BT_ZERO          = 3'b010,                   // equal
        BT_CARRY_OR_ZERO = 3'b011,                   // unsigned below or equal
        BT_SIGN          = 3'b100,                   // sign set
        BT_PARITY        = 3'b101,                   // parity even
        BT_SIGNED_LESS   = 3'b110,                   // signed less
        BT_SIGNED_LE     = 3'b111                    // signed less or equal
    } base_test_t;

    // instruction groups sharing the evaluator
    typedef enum logic [1:0] {
        GRP_COND_JUMP       = 2'b00,                 // conditional_jump
        GRP_COND_MOVE       = 2'b01,                 // conditional_move
        GRP_FLOAT_COND_MOVE = 2'b10,                 // float_conditional_move
        GRP_COND_BYTE_SET   = 2'b11                  // conditional_byte_set
    } insn_group_t;

    // the five arithmetic status flags of the processor_status_word
    typedef struct packed {
        logic parity_flag;
        logic zero_flag;
        logic sign_flag;
        logic overflow_flag;
        logic carry_flag;
    } status_flags_t;

endpackage : cond_eval_pkg

// [hdl/cond_eval_if.sv]
// carrier between the evaluator top and its condition test core
`timescale 1ns/1ps
interface cond_eval_if;
    import cond_eval_pkg::*;

    logic [SUB_W-1:0] subcode;                       // condition subcode
    status_flags_t    flags;                         // current status flags
    logic             cond_true;                     // test outcome

    modport requester (output subcode, output flags, input cond_true);
    modport evaluator (input subcode, input flags, output cond_true);
endinterface : cond_eval_if

// [hdl/condition_test_core.sv]
// combinational condition test from subcode and status flags
`timescale 1ns/1ps
module condition_test_core (
    cond_eval_if.evaluator bus
);
    import cond_eval_pkg::*;

    base_test_t base_sel;                            // upper three subcode bits
    logic       base_true;                           // outcome of the even code
    logic       sign_ne_ovf;                         // signed less term

    // only flags feed the test, nothing else of the processor
    assign base_sel    = base_test_t'(bus.subcode[SUB_W-1:1]);
    assign sign_ne_ovf = bus.flags.sign_flag ^ bus.flags.overflow_flag;

    // base test per even subcode
    always_comb begin
        case (base_sel)
            BT_OVERFLOW:      base_true = bus.flags.overflow_flag;
            BT_CARRY:         base_true = bus.flags.carry_flag;
            BT_ZERO:          base_true = bus.flags.zero_flag;
            BT_CARRY_OR_ZERO: base_true = bus.flags.carry_flag | bus.flags.zero_flag;
            BT_SIGN:          base_true = bus.flags.sign_flag;
            BT_PARITY:        base_true = bus.flags.parity_flag;
            BT_SIGNED_LESS:   base_true = sign_ne_ovf;
            BT_SIGNED_LE:     base_true = sign_ne_ovf | bus.flags.zero_flag;
            default:          base_true = 1'b0;
        endcase
    end

    // odd codes negate their even partner, which covers 0001 .. 1111
    assign bus.cond_true = base_true ^ bus.subcode[0];
endmodule : condition_test_core

// [testbench/status_flags_model.sv]
// status flags register model feeding the evaluator flag inputs
`timescale 1ns/1ps
module status_flags_model (
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst,
    input  wire logic       i_load,
    input  wire logic [4:0] i_flags,
    output logic      [4:0] o_flags
);
    logic [4:0] held_r;  // last loaded {parity,zero,sign,overflow,carry}
    // holds the flags until the next load
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) held_r <= 5'h00;
        else if (i_load) held_r <= i_flags;
    end
    // a load shows at once, so the request edge sees the flags it was issued with;
    // a plain register here would hand the evaluator the previous request's flags
    assign o_flags = i_load ? i_flags : held_r;
endmodule : status_flags_model

// [testbench/flag_condition_evaluator_asserts.sv]
// concurrent checks on the evaluator top ports
`timescale 1ns/1ps
module flag_condition_evaluator_asserts (
    input wire logic                            i_clk_sys,
    input wire logic                            i_rst,
    input wire logic                            i_ce,
    input wire logic                            i_eval_valid,
    input wire logic [cond_eval_pkg::SUB_W-1:0] i_subcode,
    input wire cond_eval_pkg::insn_group_t      i_group,
    input wire logic                            i_carry_flag,
    input wire logic                            i_overflow_flag,
    input wire logic                            i_sign_flag,
    input wire logic                            i_zero_flag,
    input wire logic                            i_parity_flag,
    input wire logic                            o_result_valid,
    input wire logic                            o_cond_true,
    input wire cond_eval_pkg::insn_group_t      o_group,
    input wire logic [7:0]                      i_reg_addr,
    input wire logic [31:0]                     i_reg_wdata,
    input wire logic                            i_reg_wr,
    input wire logic                            i_reg_rd,
    input wire logic [31:0]                     o_reg_rdata
);
    import cond_eval_pkg::*;
    logic       en_r;  // shadow of the enable bit, seen only through writes
    logic       take;  // request accepted at this edge
    logic       want;  // expected outcome of the present request
    logic [4:0] b;     // base tests, index is subcode[3:1]
    // shadow tracks writes so the checker needs no internal probes
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) en_r <= 1'b1;
        else if (i_ce && i_reg_wr && i_reg_addr == OFF_CTRL) en_r <= i_reg_wdata[CTRL_EN_BIT];
    end
    assign take = i_ce && i_eval_valid && en_r;
    assign b = {i_sign_flag, i_carry_flag | i_zero_flag, i_zero_flag, i_carry_flag, i_overflow_flag};
    // upper codes written out, lower five come from b
    always_comb begin
        case (i_subcode[3:1])
            3'h5: want = i_parity_flag;
            3'h6: want = i_sign_flag ^ i_overflow_flag;
            3'h7: want = (i_sign_flag ^ i_overflow_flag) | i_zero_flag;
            default: want = b[i_subcode[3:1]];
        endcase
        want = want ^ i_subcode[0]; // odd code negates its even partner
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    valid_pulse_a: assert property (take |=> o_result_valid)
        else $error("no result pulse after an accepted request");
    no_pulse_a: assert property ((i_ce && !take) |=> !o_result_valid)
        else $error("result pulse without an accepted request");
    result_value_a: assert property (take |=> o_cond_true == $past(want))
        else $error("condition outcome wrong for subcode and flags");
    group_echo_a: assert property (take |=> o_group == $past(i_group))
        else $error("group not echoed with result");
    hold_result_a: assert property (!take |=> $stable(o_cond_true) && $stable(o_group))
        else $error("result changed without a request");
    rdata_idle_a: assert property ((i_ce && !i_reg_rd) |=> o_reg_rdata == 32'h0)
        else $error("read data not zero outside a read");
    ctrl_read_a: assert property ((i_ce && i_reg_rd && i_reg_addr == OFF_CTRL) |=> o_reg_rdata == {31'h0, $past(en_r)})
        else $error("control readback wrong");
    unmapped_read_a: assert property ((i_ce && i_reg_rd && i_reg_addr > OFF_TRUE_CNT) |=> o_reg_rdata == 32'h0)
        else $error("unmapped read not zero");
endmodule : flag_condition_evaluator_asserts
bind flag_condition_evaluator flag_condition_evaluator_asserts u_flag_condition_evaluator_asserts (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(i_ce), .i_eval_valid(i_eval_valid), .i_subcode(i_subcode),
    .i_group(i_group), .i_carry_flag(i_carry_flag), .i_overflow_flag(i_overflow_flag), .i_sign_flag(i_sign_flag),
    .i_zero_flag(i_zero_flag), .i_parity_flag(i_parity_flag), .o_result_valid(o_result_valid),
    .o_cond_true(o_cond_true), .o_group(o_group), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata));

// [testbench/flag_condition_evaluator_tb.sv]
// self-checking bench for the flag condition evaluator
`timescale 1ns/1ps
module flag_condition_evaluator_tb;
    import cond_eval_pkg::*;
    logic        i_clk_sys = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_eval_valid = 1'b0;
    logic        i_reg_wr = 1'b0, i_reg_rd = 1'b0, ld = 1'b0, o_result_valid, o_cond_true;
    logic [3:0]  i_subcode = 4'h0;
    logic [4:0]  fl_in = 5'h00, fl;          // fl comes from the flags model
    logic [7:0]  i_reg_addr = 8'h00;
    logic [31:0] i_reg_wdata = 32'h0, o_reg_rdata, rng = 32'h4b;
    insn_group_t i_group = GRP_COND_JUMP, o_group;
    int          n_errors = 0, checked = 0, ecnt = 0, tcnt = 0, en = 1, last = 0, r;
    int          q[$];                       // expected {group,result} in order
    always #2 i_clk_sys = ~i_clk_sys;
    status_flags_model u_status_flags_model (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_load(ld), .i_flags(fl_in),
        .o_flags(fl));
    flag_condition_evaluator u_flag_condition_evaluator (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(i_ce),
        .i_eval_valid(i_eval_valid), .i_subcode(i_subcode), .i_group(i_group), .i_carry_flag(fl[0]),
        .i_overflow_flag(fl[1]), .i_sign_flag(fl[2]), .i_zero_flag(fl[3]), .i_parity_flag(fl[4]),
        .o_result_valid(o_result_valid), .o_cond_true(o_cond_true), .o_group(o_group), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata));
    // reference outcome from subcode and flags {p,z,s,o,c}
    function automatic int model(input int s, input int f);
        int c = f & 1, o = (f >> 1) & 1, sg = (f >> 2) & 1, z = (f >> 3) & 1, p = (f >> 4) & 1;
        int b[8];
        b = '{o, c, z, c | z, sg, p, sg ^ o, (sg ^ o) | z};
        return b[s >> 1] ^ (s & 1);
    endfunction : model
    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : xs
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // one request per call, back to back when called in a row
    task automatic eval(input int s, input int f, input int g);
        @(posedge i_clk_sys);
        i_eval_valid <= 1'b1;
        i_subcode <= 4'(s);
        i_group <= insn_group_t'(g);
        ld <= 1'b1;
        fl_in <= 5'(f);
        r = model(s, f);
        if (en) begin
            q.push_back(r | (g << 1));
            ecnt++;
            tcnt += r;
            last = r | (s << 4) | (f << 8) | (g << 16);
        end
    endtask : eval
    task automatic idle(input int n);
        @(posedge i_clk_sys);
        i_eval_valid <= 1'b0;
        ld <= 1'b0;
        repeat (n) @(posedge i_clk_sys);
    endtask : idle
    task automatic rw(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_clk_sys);
        i_reg_wr <= 1'b0;
    endtask : rw
    task automatic rd(input logic [7:0] a, input int exp, input string nm);
        @(posedge i_clk_sys);
        i_reg_rd <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_clk_sys);
        i_reg_rd <= 1'b0;
        @(negedge i_clk_sys);
        chk(nm, o_reg_rdata, exp);
    endtask : rd
    task automatic close_out();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : close_out
    // every pulse must match the oldest pending expectation
    always @(negedge i_clk_sys) begin
        if (!i_rst && o_result_valid === 1'b1) begin
            if (q.size() == 0) chk("spurious result", 1, 0);
            else chk("result", {o_group, o_cond_true}, q.pop_front());
        end
    end
    initial begin
        repeat (20) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        @(negedge i_clk_sys);
        chk("reset outputs", {o_result_valid, o_cond_true, o_group}, 0);
        rd(OFF_CTRL, 1, "ctrl reset");
        rd(OFF_EVAL_CNT, 0, "eval count reset");
        for (int i = 0; i < 512; i++) eval(i % 16, i / 16, i % 4);
        for (int i = 0; i < 200; i++) eval(xs() % 16, xs() % 32, xs() % 4);
        idle(3);
        rd(OFF_EVAL_CNT, ecnt, "eval count");
        rd(OFF_TRUE_CNT, tcnt, "true count");
        rw(OFF_STATUS, 32'hffff_ffff); // read-only place must ignore this
        rd(OFF_STATUS, last, "status");
        rd(8'h10, 0, "unmapped");
        rw(OFF_CTRL, 32'h0);
        en = 0;
        eval(4, 8, 1);
        idle(3);
        rd(OFF_EVAL_CNT, ecnt, "count held off");
        rw(OFF_CTRL, 32'h3); // enable again and clear counters
        en = 1;
        ecnt = 0;
        tcnt = 0;
        rd(OFF_CTRL, 1, "ctrl clear reads back");
        @(posedge i_clk_sys);
        i_ce <= 1'b0;
        i_eval_valid <= 1'b1;
        repeat (3) @(posedge i_clk_sys);
        i_ce <= 1'b1;
        i_eval_valid <= 1'b0;
        ecnt = 0;
        tcnt = 0;
        // clear and evaluation at one edge: the evaluation still counts
        fork
            rw(OFF_CTRL, 32'h3);
            begin
                eval(6, 1, 2);
                idle(0);
            end
        join
        eval(15, 0, 3);
        idle(3);
        rd(OFF_EVAL_CNT, ecnt, "count after clear");
        rd(OFF_TRUE_CNT, tcnt, "true after clear");
        chk("pending results", q.size(), 0);
        close_out();
    end
    // cut a hang short well beyond the expected run length
    initial begin
        repeat (5000) @(posedge i_clk_sys);
        n_errors++;
        close_out();
    end
endmodule : flag_condition_evaluator_tb
